// ---- logic/cwg_ctrl.sv ----
// Control, status and output logic of the complementary waveform controller
`timescale 1ns/1ps
`default_nettype none
// Operation
// - ctrl0 bit7 enables generator, resets zero
// - load strobe transfers buffers at edge, self-clears
// - load ignored unless already enabled
// - 3-bit mode selects output drive pattern
// - ctrl1 bits3..0 invert outputs D,C,B,A
// - 6-bit rising dead-band count, kept on reset
// - 6-bit falling dead-band count, kept on reset
// - shutdown status bit7 set while shut down
// - bit6 auto-restart; else software clears shutdown
// - B/D override: high, low, tri, inactive
// - A/C override same codes, reset 01
// - shutdown bit writable while disabled
// - overrides hold until next input rising edge
// - unimplemented bits read zero, ignore writes
// - auto-restart clears when sources all low
// - software clear only when sources low
// - active shutdown input blocks clearing
module cwg_ctrl #(
  parameter int NUM_SRC = 7
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  // Avalon-MM slave
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // Input waveform and active-high fault sources (already selected)
  input  wire logic                  wave_in,
  input  wire logic [NUM_SRC-1:0]    shdn_src,
  // Outputs with enables
  output logic      [3:0]            out_abcd,
  output logic      [3:0]            out_abcd_oe,
  // Interrupt
  output logic                       irq
);
  import cwg_pkg::*;

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  // One OR level over the sources; sixteen keeps that path short
  generate
    if (NUM_SRC < 1 || NUM_SRC > 16) begin : g_bad_num_src
      $error("NUM_SRC out of range");
    end
  endgenerate

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic            en_q, load_q, shdn_q, ren_q;
  logic [2:0]      mode_q, mode_act_q;
  logic [3:0]      pol_q, pol_act_q;
  logic [5:0]      rdb_q, fdb_q, rdb_act_q, fdb_act_q;
  logic [1:0]      ovr_bd_q, ovr_ac_q;
  logic [2:0]      ist_q, ien_q;
  logic            hold_q;
  logic            rd_pend_q;
  logic [7:0]      rdata_q;
  logic            in_s1_q, in_s2_q, in_s3_q;
  logic [NUM_SRC-1:0] src_s1_q, src_s2_q;
  logic [5:0]      db_cnt_q;
  logic            data_q;
  logic [3:0]      out_q, oe_q;

  // ****************************************************************
  // Synchronisers: first stage read only by second
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    in_s1_q  <= wave_in;
    in_s2_q  <= in_s1_q;
    in_s3_q  <= in_s2_q;
    src_s1_q <= shdn_src;
    src_s2_q <= src_s1_q;
  end

  // Edge and fault decode
  wire rise_ev   = in_s2_q & ~in_s3_q;
  wire fall_ev   = ~in_s2_q & in_s3_q;
  wire src_any   = |src_s2_q;
  wire wr_hit    = avs_write;
  wire wr_ctrl0  = wr_hit && (avs_address == ADDR_CTRL0);
  wire wr_ctrl1  = wr_hit && (avs_address == ADDR_CTRL1);
  wire wr_rdb    = wr_hit && (avs_address == ADDR_RISE_DB);
  wire wr_fdb    = wr_hit && (avs_address == ADDR_FALL_DB);
  wire wr_shdn   = wr_hit && (avs_address == ADDR_SHDN0);
  wire wr_ien    = wr_hit && (avs_address == ADDR_IRQ_EN);
  wire wr_iclr   = wr_hit && (avs_address == ADDR_IRQ_CLR);
  wire [7:0] wd  = avs_writedata[7:0];
  // Load request only counts when already enabled before this write
  wire load_set  = wr_ctrl0 && wd[BIT_LOAD] && en_q;
  wire load_do   = load_q && (rise_ev || fall_ev);
  // Shutdown entry: a live fault source or software writing a one
  wire shdn_set  = src_any || (wr_shdn && wd[BIT_SHDN]);
  // Software clear only succeeds with no fault present
  wire sw_clr    = wr_shdn && !wd[BIT_SHDN] && !src_any;
  wire auto_clr  = ren_q && !src_any;
  wire shdn_d    = shdn_set ? 1'b1 : ((sw_clr || auto_clr) ? 1'b0 : shdn_q);
  wire shdn_fall = shdn_q && !shdn_d;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_q     <= 1'b0;
      mode_q   <= 3'h0;
      pol_q    <= 4'h0;
      ren_q    <= 1'b0;
      ovr_bd_q <= OVR_RESET;
      ovr_ac_q <= OVR_RESET;
      ien_q    <= 3'h0;
    end else begin
      if (wr_ctrl0) en_q <= wd[BIT_EN];
      if (wr_ctrl0) mode_q <= wd[2:0];
      if (wr_ctrl1) pol_q <= wd[3:0];
      if (wr_shdn) ren_q <= wd[BIT_REN];
      if (wr_shdn) ovr_bd_q <= wd[LSB_OVR_BD +: 2];
      if (wr_shdn) ovr_ac_q <= wd[LSB_OVR_AC +: 2];
      if (wr_ien) ien_q <= wd[2:0];
    end
  end

  // Dead-band counts survive reset, so no reset branch
  always_ff @(posedge core_clk) begin
    if (wr_rdb) rdb_q <= wd[5:0];
    if (wr_fdb) fdb_q <= wd[5:0];
  end

  // Strobe, shutdown and hold state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      load_q <= 1'b0;
      shdn_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      load_q <= load_set ? 1'b1 : (load_do ? 1'b0 : load_q);
      shdn_q <= shdn_d;
      // Overrides stay until the first rising edge after release
      if (shdn_d) hold_q <= 1'b1;
      else if (rise_ev && !shdn_fall) hold_q <= 1'b0;
    end
  end

  // Active copies track the live registers while disabled, then change only at a load
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_act_q <= 3'h0;
      pol_act_q  <= 4'h0;
      rdb_act_q  <= DB_RESET;
      fdb_act_q  <= DB_RESET;
    end else if (load_do || !en_q) begin
      mode_act_q <= mode_q;
      pol_act_q  <= pol_q;
      rdb_act_q  <= rdb_q;
      fdb_act_q  <= fdb_q;
    end
  end

  // ****************************************************************
  // Interrupt status: set wins over clear
  // ****************************************************************
  // Named events; a clear in the cycle of an event leaves the event standing
  wire       ev_shdn_in  = !shdn_q && shdn_d;
  wire       ev_shdn_out = shdn_fall;
  wire       ev_loaded   = load_do;
  wire [2:0] ev_vec      = {ev_loaded, ev_shdn_out, ev_shdn_in};
  wire [2:0] clr_vec     = wr_iclr ? wd[2:0] : 3'h0;
  always_ff @(posedge core_clk) begin
    if (srst) ist_q <= 3'h0;
    else ist_q <= ev_vec | (ist_q & ~clr_vec);
  end
  assign irq = |(ist_q & ien_q);

  // ****************************************************************
  // Dead-band timer: count of generator clock periods
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      db_cnt_q <= 6'h00;
      data_q   <= 1'b0;
    end else if (rise_ev) begin
      db_cnt_q <= rdb_act_q;
      data_q   <= 1'b1;
    end else if (fall_ev) begin
      db_cnt_q <= fdb_act_q;
      data_q   <= 1'b0;
    end else if (db_cnt_q != 6'h00) begin
      db_cnt_q <= db_cnt_q - 6'h01;
    end
  end
  wire db_busy = (db_cnt_q != 6'h00) || rise_ev || fall_ev;

  // ****************************************************************
  // Output pattern per mode
  // ****************************************************************
  logic [3:0] raw;
  always_comb begin
    raw = 4'h0;
    case (mode_act_q)
      CWG_MODE_STEER, CWG_MODE_SSTEER: raw = {4{data_q}};
      CWG_MODE_FWD:  raw = {data_q, 1'b0, 1'b0, 1'b1};
      CWG_MODE_REV:  raw = {1'b0, 1'b1, data_q, 1'b0};
      CWG_MODE_HALF: raw = {!data_q && !db_busy, data_q && !db_busy,
                            !data_q && !db_busy, data_q && !db_busy};
      CWG_MODE_PP:   raw = {!data_q, data_q, !data_q, data_q};
      default:       raw = 4'h0;
    endcase
  end

  // Per-pin override selection; generate over the four outputs
  wire [3:0] act_n = raw ^ pol_act_q;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      wire [1:0] ov = (gi % 2 == 1) ? ovr_bd_q : ovr_ac_q; // Odd pins are B and D
      wire inact = pol_act_q[gi];
      always_ff @(posedge core_clk) begin
        if (srst) begin
          out_q[gi] <= 1'b0;
          oe_q[gi]  <= 1'b0;
        end else if (!en_q && !shdn_q) begin
          out_q[gi] <= 1'b0;
          oe_q[gi]  <= 1'b0;
        end else if (hold_q || shdn_q) begin
          out_q[gi] <= (ov == OVR_HIGH) ? 1'b1 : ((ov == OVR_LOW) ? 1'b0 : inact);
          oe_q[gi]  <= (ov != OVR_TRI);
        end else begin
          out_q[gi] <= act_n[gi];
          oe_q[gi]  <= 1'b1;
        end
      end
    end
  endgenerate
  // Pins come straight from flops so no decode glitch reaches a gate driver
  assign out_abcd    = out_q;
  assign out_abcd_oe = oe_q;

  // ****************************************************************
  // Avalon read: one wait state, answer registered
  // ****************************************************************
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    case (avs_address)
      ADDR_CTRL0:   rmux = {en_q, load_q, 3'h0, mode_q};
      ADDR_CTRL1:   rmux = {2'h0, in_s2_q, 1'b0, pol_q};
      ADDR_RISE_DB: rmux = {2'h0, rdb_q};
      ADDR_FALL_DB: rmux = {2'h0, fdb_q};
      ADDR_SHDN0:   rmux = {shdn_q, ren_q, ovr_bd_q, ovr_ac_q, 2'h0};
      ADDR_IRQ_ST:  rmux = {5'h00, ist_q};
      ADDR_IRQ_EN:  rmux = {5'h00, ien_q};
      default:      rmux = 8'h00;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_pend_q <= 1'b0;
      rdata_q   <= 8'h00;
    end else begin
      rd_pend_q <= avs_read && !rd_pend_q;
      rdata_q   <= rmux;
    end
  end
  // Writes never wait; a read waits one cycle so its answer comes from a flop
  assign avs_waitrequest = avs_read && !rd_pend_q;
  assign avs_readdata    = {24'h000000, rdata_q};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_load_gate: assert property (@(posedge core_clk) disable iff (srst)
    (!load_q && !en_q) |=> !load_q) else $error("load set while disabled");
  chk_load_clear: assert property (@(posedge core_clk) disable iff (srst)
    (load_q && (rise_ev || fall_ev)) |=> !load_q) else $error("load not cleared");
  chk_shdn_fault: assert property (@(posedge core_clk) disable iff (srst)
    src_any |=> shdn_q) else $error("fault did not hold shutdown");
  chk_auto_restart: assert property (@(posedge core_clk) disable iff (srst)
    (shdn_q && ren_q && !src_any && !wr_shdn) |=> !shdn_q) else $error("no auto restart");
  chk_sw_hold: assert property (@(posedge core_clk) disable iff (srst)
    (shdn_q && !ren_q && !wr_shdn && !src_any) |=> shdn_q) else $error("shutdown lost");
  chk_hold_edge: assert property (@(posedge core_clk) disable iff (srst)
    ($fell(shdn_q) && !rise_ev) |=> hold_q) else $error("override released early");
  chk_tri_pin: assert property (@(posedge core_clk) disable iff (srst)
    (shdn_q && ovr_bd_q == OVR_TRI) |=> !oe_q[1]) else $error("pin B not tristated");
  chk_db_count: assert property (@(posedge core_clk) disable iff (srst)
    (db_cnt_q == 6'h02 && !rise_ev && !fall_ev) |=> db_cnt_q == 6'h01) else $error("dead band");
  chk_rd_wait: assert property (@(posedge core_clk) disable iff (srst)
    (avs_read && !rd_pend_q) |=> !avs_waitrequest) else $error("read stalled");
  // Software shutdown must win, disabled or not
  chk_sw_set: assert property (@(posedge core_clk) disable iff (srst)
    (wr_shdn && wd[BIT_SHDN]) |=> shdn_q) else $error("software shutdown lost");
  // A software zero with no fault present takes effect at once
  chk_sw_clear: assert property (@(posedge core_clk) disable iff (srst)
    (wr_shdn && !wd[BIT_SHDN] && !src_any) |=> !shdn_q) else $error("software clear refused");
  // The first rising edge with no shutdown pending ends the hold
  chk_hold_end: assert property (@(posedge core_clk) disable iff (srst)
    (rise_ev && !shdn_q && !shdn_d) |=> !hold_q) else $error("override kept after edge");
  // Disabled and not shut down: nothing is driven onto the bridge
  chk_idle_off: assert property (@(posedge core_clk) disable iff (srst)
    (!en_q && !shdn_q) |=> (oe_q == 4'h0)) else $error("pins driven while disabled");
  // Drive-high override on the B/D pair
  chk_ovr_high: assert property (@(posedge core_clk) disable iff (srst)
    (shdn_q && ovr_bd_q == OVR_HIGH) |=> (out_q[1] && out_q[3])) else $error("B/D not high");
  // Tri-state override on the A/C pair releases both pins
  chk_tri_ac: assert property (@(posedge core_clk) disable iff (srst)
    (shdn_q && ovr_ac_q == OVR_TRI) |=> (!oe_q[0] && !oe_q[2])) else $error("A/C still driven");
  // A load copies the buffered polarity into the active set
  chk_load_copy: assert property (@(posedge core_clk) disable iff (srst)
    load_do |=> (pol_act_q == $past(pol_q))) else $error("buffers not loaded");
  // Dead-band counter starts from the active rising count after a rising edge
  chk_db_start: assert property (@(posedge core_clk) disable iff (srst)
    rise_ev |=> (db_cnt_q == $past(rdb_act_q))) else $error("dead band start");
  // Input status bit shows the synchronised level, not the raw pin
  chk_in_level: assert property (@(posedge core_clk) disable iff (srst)
    (avs_read && avs_address == ADDR_CTRL1) |=> (avs_readdata[BIT_IN] == $past(in_s2_q)))
    else $error("input level wrong");
  // Unmapped addresses read back as zero
  chk_unmapped_rd: assert property (@(posedge core_clk) disable iff (srst)
    (avs_read && avs_address[1:0] != 2'h0) |=> (avs_readdata == 32'h00000000))
    else $error("unmapped read not zero");
  // A clear in the event cycle must not swallow the event
  chk_irq_set: assert property (@(posedge core_clk) disable iff (srst)
    ev_shdn_in |=> ist_q[IRQ_SHDN]) else $error("interrupt event lost");
  // ****************************************************************
  // Coverage of the main scenarios
  // ****************************************************************
  cov_shutdown: cover property (@(posedge core_clk) $rose(shdn_q));
  cov_restart:  cover property (@(posedge core_clk) $fell(hold_q));
  cov_load:     cover property (@(posedge core_clk) load_do);
  cov_deadband: cover property (@(posedge core_clk) db_cnt_q == 6'h01);
  cov_irq:      cover property (@(posedge core_clk) $rose(irq));
endmodule : cwg_ctrl
`default_nettype wire

// ---- logic/cwg_pkg.sv ----
// Package for the complementary waveform controller: map, fields, resets, modes
package cwg_pkg;
  // ****************************************************************
  // Register byte addresses (Avalon word aligned)
  // ****************************************************************
  localparam logic [4:0] ADDR_CTRL0   = 5'h00;
  localparam logic [4:0] ADDR_CTRL1   = 5'h04;
  localparam logic [4:0] ADDR_RISE_DB = 5'h08;
  localparam logic [4:0] ADDR_FALL_DB = 5'h0C;
  localparam logic [4:0] ADDR_SHDN0   = 5'h10;
  localparam logic [4:0] ADDR_IRQ_ST  = 5'h14;
  localparam logic [4:0] ADDR_IRQ_EN  = 5'h18;
  localparam logic [4:0] ADDR_IRQ_CLR = 5'h1C;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_EN       = 7;
  localparam int BIT_LOAD     = 6;
  localparam int BIT_IN       = 5;
  localparam int BIT_SHDN     = 7;
  localparam int BIT_REN      = 6;
  localparam int LSB_OVR_BD   = 4;
  localparam int LSB_OVR_AC   = 2;
  localparam int IRQ_SHDN     = 0;
  localparam int IRQ_RESTART  = 1;
  localparam int IRQ_LOADED   = 2;
  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [1:0] OVR_RESET    = 2'h1;
  localparam logic [1:0] OVR_HIGH     = 2'h3;
  localparam logic [1:0] OVR_LOW      = 2'h2;
  localparam logic [1:0] OVR_TRI      = 2'h1;
  localparam logic [5:0] DB_RESET     = 6'h00;
  localparam int DB_W = 6;
  typedef enum logic [2:0] {
    CWG_MODE_STEER  = 3'b000,
    CWG_MODE_SSTEER = 3'b001,
    CWG_MODE_FWD    = 3'b010,
    CWG_MODE_REV    = 3'b011,
    CWG_MODE_HALF   = 3'b100,
    CWG_MODE_PP     = 3'b101
  } cwg_mode_e;
endpackage : cwg_pkg

// ---- tb/cwg_bridge_model.sv ----
// Model of the bridge gate drivers that face the four waveform outputs
`timescale 1ns/1ps
`default_nettype none
module cwg_bridge_model (
  // Clock
  input  wire logic       core_clk,
  // Waveform pins from the block
  input  wire logic [3:0] out_abcd,
  input  wire logic [3:0] out_abcd_oe,
  // Trip request from the bench and the fault flag it produces
  input  wire logic       trip_cmd,
  output logic            fault,
  output logic      [3:0] gate_lvl
);
  // Gate inputs carry pull-downs, so a released pin reads low, never a stale level
  assign gate_lvl = out_abcd & out_abcd_oe;
  // Overcurrent flag changes on the clock, like a real comparator latch
  always_ff @(posedge core_clk) begin
    fault <= trip_cmd;
  end
endmodule : cwg_bridge_model
`default_nettype wire

// ---- tb/cwg_ctrl_bench.sv ----
// Self-checking bench for the complementary waveform controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module cwg_ctrl_bench;
  import cwg_pkg::*;
  logic        core_clk, srst, avs_read, avs_write, wave_in, trip_cmd, irq, fault;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  out_abcd, out_abcd_oe, gate_lvl;
  logic [7:0]  rdata;
  int          n_mismatch, n_checks, cycles;
  // ****************************************************************
  // Clock, design and partner
  // ****************************************************************
  always #50 core_clk = ~core_clk;
  cwg_ctrl #(.NUM_SRC(7)) u_cwg_ctrl (
    .core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wave_in(wave_in), .shdn_src({6'h00, fault}),
    .out_abcd(out_abcd), .out_abcd_oe(out_abcd_oe), .irq(irq));
  cwg_bridge_model u_cwg_bridge_model (
    .core_clk(core_clk), .out_abcd(out_abcd), .out_abcd_oe(out_abcd_oe),
    .trip_cmd(trip_cmd), .fault(fault), .gate_lvl(gate_lvl));
  // ****************************************************************
  // Bus, pin and stimulus helpers
  // ****************************************************************
  // Request held until waitrequest is seen low; a gap cycle avoids double drive
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(rdata, e)
  endtask : rd_chk
  task automatic pin_chk(input logic [3:0] lvl, input logic [3:0] oe);
    `CHK(gate_lvl, lvl)
    `CHK(out_abcd_oe, oe)
  endtask : pin_chk
  // Sync, edge detect and output register need four cycles; eight gives margin
  task automatic wave(input logic v);
    @(posedge core_clk);
    wave_in <= v;
    repeat (8) @(posedge core_clk);
  endtask : wave
  task automatic trip(input logic v);
    @(posedge core_clk);
    trip_cmd <= v;
    repeat (8) @(posedge core_clk);
  endtask : trip
  // Outputs must sit low through the dead band and take the level after it
  task automatic db_chk(input logic v, input logic [3:0] lvl);
    wave(v);
    pin_chk(4'h0, 4'hF);
    repeat (3) @(posedge core_clk);
    pin_chk(lvl, 4'hF);
  endtask : db_chk
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd_chk(ADDR_CTRL0, 8'h00);
    rd_chk(ADDR_SHDN0, 8'h14);
    wr(5'h02, 8'hFF);
    rd_chk(5'h02, 8'h00);
    rd_chk(ADDR_CTRL0, 8'h00);
    pin_chk(4'h0, 4'h0);
  endtask : t_reset
  task automatic t_regs();
    wr(ADDR_RISE_DB, 8'hFF);
    rd_chk(ADDR_RISE_DB, 8'h3F);
    wr(ADDR_FALL_DB, 8'hFF);
    rd_chk(ADDR_FALL_DB, 8'h3F);
    wr(ADDR_RISE_DB, 8'h00);
    wr(ADDR_FALL_DB, 8'h00);
    wr(ADDR_CTRL1, 8'hFF);
    rd_chk(ADDR_CTRL1, 8'h0F);
    wr(ADDR_CTRL1, 8'h00);
    wave(1'b1);
    rd_chk(ADDR_CTRL1, 8'h20);
    wave(1'b0);
  endtask : t_regs
  // Shutdown forced while disabled: each override code, then inactive level with polarity
  task automatic t_shdn_idle();
    wr(ADDR_SHDN0, 8'hB8);
    wave(1'b0);
    pin_chk(4'hA, 4'hF);
    rd_chk(ADDR_SHDN0, 8'hB8);
    wr(ADDR_SHDN0, 8'h94);
    wave(1'b0);
    pin_chk(4'h0, 4'h0);
    wr(ADDR_CTRL1, 8'h0A);
    wr(ADDR_SHDN0, 8'h80);
    wave(1'b0);
    pin_chk(4'hA, 4'hF);
    wr(ADDR_CTRL1, 8'h00);
  endtask : t_shdn_idle
  task automatic t_enable_load();
    wr(ADDR_CTRL0, 8'hC0);
    rd_chk(ADDR_CTRL0, 8'h80);
    for (int m = 0; m < 6; m++) begin
      wr(ADDR_CTRL0, 8'h80 | 8'(m));
      rd_chk(ADDR_CTRL0, 8'h80 | 8'(m));
    end
    wr(ADDR_CTRL0, 8'h80);
    wr(ADDR_SHDN0, 8'hB8);
    wr(ADDR_SHDN0, 8'h38);
    wave(1'b0);
    pin_chk(4'hA, 4'hF);
    wave(1'b1);
    pin_chk(4'hF, 4'hF);
    wr(ADDR_CTRL1, 8'h05);
    wave(1'b1);
    pin_chk(4'hF, 4'hF);
    wr(ADDR_CTRL0, 8'hC0);
    wave(1'b0);
    pin_chk(4'h5, 4'hF);
    rd_chk(ADDR_CTRL0, 8'h80);
    wr(ADDR_CTRL1, 8'h00);
    wr(ADDR_CTRL0, 8'hC0);
    wave(1'b1);
    pin_chk(4'hF, 4'hF);
  endtask : t_enable_load
  // Fault with software restart, interrupt raised, masked and cleared
  task automatic t_fault_irq();
    wr(ADDR_IRQ_CLR, 8'h07);
    wr(ADDR_IRQ_EN, 8'h01);
    trip(1'b1);
    rd_chk(ADDR_SHDN0, 8'hB8);
    `CHK(irq, 1'b1)
    pin_chk(4'hA, 4'hF);
    wr(ADDR_SHDN0, 8'h38);
    rd_chk(ADDR_SHDN0, 8'hB8);
    trip(1'b0);
    rd_chk(ADDR_SHDN0, 8'hB8);
    wr(ADDR_SHDN0, 8'h38);
    rd_chk(ADDR_SHDN0, 8'h38);
    wr(ADDR_IRQ_EN, 8'h00);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'b0)
    rd_chk(ADDR_IRQ_ST, 8'h03);
    wr(ADDR_IRQ_CLR, 8'h03);
    rd_chk(ADDR_IRQ_ST, 8'h00);
    wave(1'b0);
    wave(1'b1);
  endtask : t_fault_irq
  task automatic t_auto();
    wr(ADDR_SHDN0, 8'h78);
    trip(1'b1);
    rd_chk(ADDR_SHDN0, 8'hF8);
    trip(1'b0);
    rd_chk(ADDR_SHDN0, 8'h78);
    pin_chk(4'hA, 4'hF);
    wave(1'b0);
    wave(1'b1);
    pin_chk(4'hF, 4'hF);
  endtask : t_auto
  // Half-bridge holds both sides low for the dead band; push-pull ignores it
  task automatic t_modes();
    wr(ADDR_RISE_DB, 8'h06);
    wr(ADDR_FALL_DB, 8'h06);
    wr(ADDR_CTRL0, 8'hC4);
    wave(1'b0);
    pin_chk(4'hA, 4'hF);
    db_chk(1'b1, 4'h5);
    db_chk(1'b0, 4'hA);
    wr(ADDR_CTRL0, 8'hC5);
    wave(1'b1);
    pin_chk(4'h5, 4'hF);
    wave(1'b0);
    pin_chk(4'hA, 4'hF);
  endtask : t_modes
  // ****************************************************************
  // Verdict, watchdog and main sequence
  // ****************************************************************
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // Whole run needs a few hundred cycles; the ceiling leaves ample margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    {core_clk, avs_read, avs_write, wave_in, trip_cmd} = 5'h00;
    {n_mismatch, n_checks, cycles} = '0;
    srst = 1'b1;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_regs();
    t_shdn_idle();
    t_enable_load();
    t_fault_irq();
    t_auto();
    t_modes();
    print_verdict();
  end
endmodule : cwg_ctrl_bench
`default_nettype wire
